// [logic/rtiar_remap.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtiar_cfg.svh"

module rtiar_remap
    import rtiar_pkg::*;
#(
    parameter int NUM_PORTS   = 4,
    parameter int FIRST_ENTRY = 2,
    parameter int NUM_ENTRIES = 5
)
(
    input  wire logic                         CLOCK_IN,
    input  wire logic                         RST_IN,
    input  wire logic [$clog2(NUM_PORTS)-1:0] PORT_SEL_IN,
    input  wire logic                         REG_WR_IN,
    input  wire logic [7:0]                   REG_ADDR_IN,
    input  wire logic [7:0]                   REG_WDATA_IN,
    output var  logic [7:0]                   REG_RDATA_OUT,
    output var  logic                         REG_HIT_OUT,
    input  wire logic                         XACT_VALID_IN,
    input  wire logic [$clog2(NUM_PORTS)-1:0] XACT_PORT_IN,
    input  wire logic [6:0]                   XACT_ADDR_IN,
    input  wire logic [NUM_PORTS*NUM_ENTRIES*7-1:0] ALIAS_TABLE_IN,
    output var  logic                         FWD_VALID_OUT,
    output var  logic [$clog2(NUM_PORTS)-1:0] FWD_PORT_OUT,
    output var  logic [6:0]                   FWD_ADDR_OUT
);

    localparam int PW    = $clog2(NUM_PORTS);
    localparam int AW    = $bits(rtiar_addr7_t);
    localparam int SLOTS = NUM_PORTS * NUM_ENTRIES;

    // Register side: the port select register is held outside this block and arrives on PORT_SEL_IN.
    // A write is taken on the rising edge at which REG_WR_IN is high; only bits 7:1 are kept.
    // Reads are combinational: REG_RDATA_OUT and REG_HIT_OUT follow REG_ADDR_IN in the same cycle.
    // Transaction side: XACT_VALID_IN marks one local transaction address for one cycle.
    // The forwarded copy appears on the FWD ports one cycle later and stands for that one cycle.
    // Transactions may follow each other every cycle; nothing is queued, so none is lost or delayed.

    // The port number indexes the tables directly, so only a power of two of ports is served.
    // A single port would leave the port select with no bits at all.
    if (NUM_PORTS < 2
        || (1 << PW) != NUM_PORTS)
    begin : g_bad_ports
        $error("rtiar_remap: the port count must be a power of two, at least two.");
    end

    // Entries sit at consecutive offsets, and a port has no more than eight of them.
    // The entry range may start below entry 2, as long as it stays inside the eight.
    if (FIRST_ENTRY < 0 || NUM_ENTRIES < 1
        || FIRST_ENTRY + NUM_ENTRIES > `RTIAR_ENTRY_COUNT)
    begin : g_bad_entries
        $error("rtiar_remap: the entries must lie within the eight entries of a port.");
    end

    // Stored physical addresses of all ports, slot (port * NUM_ENTRIES + entry) at AW bits each.
    wire  logic [SLOTS*AW-1:0]       phys_flat;
    // Stored physical addresses of the transaction's port, one field per entry.
    wire  logic [NUM_ENTRIES*AW-1:0] xact_phys;
    // One flag per entry, set while the register offset selects that entry.
    wire  logic [NUM_ENTRIES-1:0]    ofs_hit;
    // One flag per entry, set while the transaction's address equals a live alias of its port.
    wire  logic [NUM_ENTRIES-1:0]    alias_hit;
    rtiar_byte_t                     rdata_d;
    logic                            hit_d;
    logic                            fwd_valid_q;
    logic                            fwd_valid_d;
    logic [PW-1:0]                   fwd_port_q;
    logic [PW-1:0]                   fwd_port_d;
    rtiar_addr7_t                    fwd_addr_q;
    rtiar_addr7_t                    fwd_addr_d;

    // Offset decode and alias compare, once per entry number.
    // The alias table is owned outside this block and is taken as a level.
    for (genvar e = 0; e < NUM_ENTRIES; e++)
    begin : g_entry
        // Offset of this entry in the register map.
        localparam logic [7:0] OFS = 8'(`RTIAR_OFS_TARGET_2 - `RTIAR_TARGET_2_NUM + FIRST_ENTRY + e);

        wire rtiar_addr7_t alias_val;

        assign ofs_hit[e] = (REG_ADDR_IN == OFS);

        assign alias_val =
            ALIAS_TABLE_IN[(int'(XACT_PORT_IN) * NUM_ENTRIES + e) * AW +: AW];

        assign alias_hit[e] = XACT_VALID_IN
                              && alias_val != `RTIAR_ALIAS_OFF
                              && alias_val == XACT_ADDR_IN;

        assign xact_phys[e*AW +: AW] =
            phys_flat[(int'(XACT_PORT_IN) * NUM_ENTRIES + e) * AW +: AW];
    end

    // One physical address register per receive port and entry.
    // A write lands at the edge at which the strobe is seen and reads back in the next cycle.
    // Writes to offsets outside the entries leave every register alone; a write changes only the selected port's copy.
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        for (genvar e = 0; e < NUM_ENTRIES; e++)
        begin : g_slot
            localparam int SLOT = p * NUM_ENTRIES + e;

            rtiar_addr7_t target_q;
            rtiar_addr7_t target_d;

            // Hold unless this port's copy of this entry is written.
            always_comb
            begin
                target_d = target_q;
                if (REG_WR_IN && PORT_SEL_IN == PW'(p) && ofs_hit[e])
                begin
                    target_d = REG_WDATA_IN[`RTIAR_ADDR_MSB:`RTIAR_ADDR_LSB];
                end
            end

            always_ff @(posedge CLOCK_IN)
            begin
                if (RST_IN)
                begin
                    target_q <= `RTIAR_TARGET_RESET;
                end
                else
                begin
                    target_q <= target_d;
                end
            end

            // Publish this slot in the packed table.
            assign phys_flat[SLOT*AW +: AW] = target_q;
        end
    end

    // Read data follows the offset in the same cycle, so a reader may sample it once the offset stands.
    // The reserved bit 0 always reads zero, and an offset outside the entries reads all zero.
    always_comb
    begin
        rdata_d = 8'h00;
        hit_d   = 1'b0;
        for (int e = 0; e < NUM_ENTRIES; e++)
        begin
            if (ofs_hit[e])
            begin
                hit_d   = 1'b1;
                rdata_d = {phys_flat[(int'(PORT_SEL_IN) * NUM_ENTRIES + e) * AW +: AW],
                           1'b0};
            end
        end
    end

    // The scan runs downwards, so the lowest-numbered matching entry is the one applied.
    // Without a match the forwarded address rests at zero, so no local address leaks past this stage.
    always_comb
    begin
        fwd_valid_d = 1'b0;
        // The port travels with every transaction, matched or not.
        fwd_port_d  = XACT_PORT_IN;
        fwd_addr_d  = `RTIAR_FWD_ADDR_IDLE;
        for (int e = NUM_ENTRIES - 1; e >= 0; e--)
        begin
            if (alias_hit[e])
            begin
                fwd_valid_d = 1'b1;
                fwd_addr_d  = xact_phys[e*AW +: AW];
            end
        end
    end

    // The forward stage holds a transaction for exactly one cycle.
    // The control channel must take it in that cycle, as nothing holds it longer.
    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            fwd_valid_q <= 1'b0;
            fwd_port_q  <= '0;
            fwd_addr_q  <= `RTIAR_FWD_ADDR_IDLE;
        end
        else
        begin
            fwd_valid_q <= fwd_valid_d;
            fwd_port_q  <= fwd_port_d;
            fwd_addr_q  <= fwd_addr_d;
        end
    end

    always_comb
    begin
        FWD_VALID_OUT = fwd_valid_q;
        FWD_PORT_OUT  = fwd_port_q;
        FWD_ADDR_OUT  = fwd_addr_q;
    end

    // Register read answers are combinational.
    always_comb
    begin
        REG_RDATA_OUT = rdata_d;
        REG_HIT_OUT   = hit_d;
    end

endmodule : rtiar_remap
`default_nettype wire

// [logic/rtiar_cfg.svh]
`ifndef RTIAR_CFG_SVH
`define RTIAR_CFG_SVH

// Register offsets of the remote target physical address entries and of the port select register.
`define RTIAR_OFS_TARGET_2   8'h5f
`define RTIAR_OFS_TARGET_3   8'h60
`define RTIAR_OFS_TARGET_4   8'h61
`define RTIAR_OFS_TARGET_5   8'h62
`define RTIAR_OFS_TARGET_6   8'h63
`define RTIAR_OFS_PORT_SEL   8'h4c

// Field layout and reset value of an entry, and the alias value that marks an alias as off.
`define RTIAR_ADDR_MSB       7
`define RTIAR_ADDR_LSB       1
`define RTIAR_TARGET_RESET   7'h00
`define RTIAR_ALIAS_OFF      7'h00

// Entry number that sits at the first entry offset, and the number of entries a port can have.
`define RTIAR_TARGET_2_NUM   2
`define RTIAR_ENTRY_COUNT    8

// Forwarded address shown while no transaction is forwarded.
`define RTIAR_FWD_ADDR_IDLE  7'h00

`endif

// [logic/rtiar_pkg.sv]
package rtiar_pkg;

    typedef logic [6:0] rtiar_addr7_t;
    typedef logic [7:0] rtiar_byte_t;

endpackage : rtiar_pkg

// [testbench/rtiar_remap_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module rtiar_remap_monitor #(parameter int NUM_PORTS = 4) (
    input wire logic                         CLOCK_IN,
    input wire logic                         RST_IN,
    input wire logic [7:0]                   REG_ADDR_IN,
    input wire logic [7:0]                   REG_RDATA_OUT,
    input wire logic                         REG_HIT_OUT,
    input wire logic                         XACT_VALID_IN,
    input wire logic [$clog2(NUM_PORTS)-1:0] XACT_PORT_IN,
    input wire logic [6:0]                   XACT_ADDR_IN,
    input wire logic                         FWD_VALID_OUT,
    input wire logic [$clog2(NUM_PORTS)-1:0] FWD_PORT_OUT
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    a_hit_window: assert property (REG_HIT_OUT == (REG_ADDR_IN inside {[8'h5f:8'h63]}))
        else $error("hit flag wrong");
    a_unmapped_zero: assert property (!REG_HIT_OUT |-> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    a_rsvd_bit: assert property (!REG_RDATA_OUT[0])
        else $error("bit 0 set");
    a_fwd_cause: assert property (FWD_VALID_OUT |-> $past(XACT_VALID_IN))
        else $error("forward without request");
    a_fwd_port: assert property (FWD_VALID_OUT |-> FWD_PORT_OUT == $past(XACT_PORT_IN))
        else $error("forward port wrong");
    a_reset_quiet: assert property ($past(RST_IN) |-> !FWD_VALID_OUT)
        else $error("forward right after reset");
    a_alias_zero: assert property (XACT_VALID_IN && XACT_ADDR_IN == 7'h00 |=> !FWD_VALID_OUT)
        else $error("zero address forwarded");
endmodule : rtiar_remap_monitor
`default_nettype wire

// [testbench/rtiar_far_side.sv]
`timescale 1ns/100ps
`default_nettype none
module rtiar_far_side (
    output var logic [139:0] alias_table_out
);
    always_comb
    begin
        alias_table_out = '0;
        for (int e = 0; e < 5; e++)
            alias_table_out[(5 + e) * 7 +: 7] = 7'h20 + 7'(e);
    end
endmodule : rtiar_far_side
`default_nettype wire

// [testbench/rtiar_remap_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module rtiar_remap_bench;
    import rtiar_pkg::*;
    logic clk = 0, rst = 1, wr = 0, xv = 0, hit, fv;
    logic [1:0] sel = 0, xp = 0, fp;
    rtiar_byte_t addr = 0, wd = 0, rd;
    rtiar_addr7_t xa = 0, fa;
    logic [139:0] tab;
    int bad_count = 0, checks_done = 0;
    rtiar_far_side far (.alias_table_out(tab));
    rtiar_remap uut (.CLOCK_IN(clk), .RST_IN(rst), .PORT_SEL_IN(sel), .REG_WR_IN(wr), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wd), .REG_RDATA_OUT(rd), .REG_HIT_OUT(hit), .XACT_VALID_IN(xv), .XACT_PORT_IN(xp),
        .XACT_ADDR_IN(xa), .ALIAS_TABLE_IN(tab), .FWD_VALID_OUT(fv), .FWD_PORT_OUT(fp), .FWD_ADDR_OUT(fa));
    task automatic chk(input string n, input logic [7:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rdc(input logic [1:0] p, input rtiar_byte_t a, e);
        @(posedge clk);
        sel <= p;
        addr <= a;
        #1 chk("read", rd, e);
        chk("hit", {7'h00, hit}, {7'h00, (a inside {[8'h5f:8'h63]})});
    endtask : rdc
    task automatic xact(input logic [1:0] p, input rtiar_addr7_t a, input logic v, input rtiar_addr7_t e);
        @(posedge clk);
        xv <= 1'b1;
        xp <= p;
        xa <= a;
        @(posedge clk);
        xv <= 1'b0;
        #1 chk("fwd valid", {7'h00, fv}, {7'h00, v});
        if (v)
            chk("fwd addr", {1'b0, fa}, {1'b0, e});
        if (v)
            chk("fwd port", {6'h00, fp}, {6'h00, p});
    endtask : xact
    task automatic t_regs;
        for (int i = 0; i < 5; i++)
            rdc(2'h1, 8'h5f + 8'(i), 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            sel <= 2'h1;
            addr <= 8'h5f + 8'(i);
            wd <= 8'h2b + 8'h22 * 8'(i);
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            rdc(2'h1, 8'h5f + 8'(i), (8'h2b + 8'h22 * 8'(i)) & 8'hfe);
            rdc(2'h0, 8'h5f + 8'(i), 8'h00);
        end
        rdc(2'h1, 8'h64, 8'h00);
    endtask : t_regs
    task automatic t_xlate;
        for (int e = 0; e < 5; e++)
            xact(2'h1, 7'h20 + 7'(e), 1'b1, 7'((8'h2b + 8'h22 * 8'(e)) >> 1));
        xact(2'h0, 7'h20, 1'b0, 7'h00);
        xact(2'h1, 7'h00, 1'b0, 7'h00);
        xact(2'h0, 7'h00, 1'b0, 7'h00);
    endtask : t_xlate
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rdc(2'h1, 8'h5f + 8'(i), 8'h00);
        chk("fwd idle", {7'h00, fv}, 8'h00);
        xact(2'h1, 7'h20, 1'b1, 7'h00);
    endtask : t_reset
    task automatic tally_and_finish;
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial
        forever #2 clk = ~clk;
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_xlate;
        t_reset;
        tally_and_finish;
    end
    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish;
    end
endmodule : rtiar_remap_bench
bind rtiar_remap rtiar_remap_monitor #(.NUM_PORTS(NUM_PORTS)) mon (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_HIT_OUT(REG_HIT_OUT), .XACT_VALID_IN(XACT_VALID_IN),
    .XACT_PORT_IN(XACT_PORT_IN), .XACT_ADDR_IN(XACT_ADDR_IN), .FWD_VALID_OUT(FWD_VALID_OUT), .FWD_PORT_OUT(FWD_PORT_OUT));
`default_nettype wire
